// ### core/msp_defs.vh
// constants shared by the monitor two-wire slave port
// assumes it is included by bare name from files under core/
`ifndef MSP_DEFS_VH
`define MSP_DEFS_VH

// seven-bit slave address base, low two bits come from the select pins
`define MSP_BASE_ADDR 7'h4C
// global sync address (write only), seven-bit form of the 8-bit EE
`define MSP_SYNC_ADDR 7'h77

// register map indices
`define MSP_REG_STATUS 4'h0
`define MSP_REG_CONTROL 4'h1
`define MSP_REG_TRIGGER 4'h2
`define MSP_REG_FIRST_RES 4'h4

// reset value of the control register and of every result register
`define MSP_REG_RESET 8'h00

// data-valid flag position in a result high byte
`define MSP_DV_BIT 7

// received bits in one byte
`define MSP_BYTE_BITS 4'h8
// last bit index while shifting out
`define MSP_LAST_TX_BIT 4'h7

`endif

// ### core/msp_sync.v
// three-stage synchroniser for pins that arrive from outside mclk
// assumes one clock mclk and an asynchronous active-low reset
`default_nettype none

module msp_sync #(
  parameter WIDTH = 4
) (
  input wire mclk,
  input wire rst_b,
  input wire [WIDTH-1:0] din,
  output wire [WIDTH-1:0] mid,
  output wire [WIDTH-1:0] old
);

  genvar gi;

  // one chain per bit; the first stage feeds only the second
  generate
    for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_bit
      reg s1;
      reg s2;
      reg s3;
      always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
          s1 <= 1'b1;
          s2 <= 1'b1;
          s3 <= 1'b1;
        end else begin
          s1 <= din[gi];
          s2 <= s1;
          s3 <= s2;
        end
      end
      assign mid[gi] = s2;
      assign old[gi] = s3;
    end
  endgenerate

endmodule

`default_nettype wire

// ### core/msp_slave_port.v
// two-wire slave port of a voltage, current and temperature monitor
// assumes a 100 MHz mclk, pull-ups on the bus wires outside the chip,
// and a measurement sequencer on mclk that posts results byte by byte
`default_nettype none
`include "msp_defs.vh"

module msp_slave_port (
  input wire mclk,
  input wire rst_b,
  input wire scl_in,
  input wire sda_in,
  output wire sda_out,
  output reg sda_oe,
  input wire addr_select_pin_0,
  input wire addr_select_pin_1,
  input wire res_wr,
  input wire [3:0] res_idx,
  input wire [7:0] res_data,
  output wire res_ready,
  input wire conv_busy,
  output reg conv_trigger,
  output wire ctrl_kelvin,
  output wire ctrl_single,
  output wire [4:0] ctrl_mode,
  output wire diode_drive_en
);

  // one-hot protocol states
  localparam [7:0] ST_IDLE = 8'h01;
  localparam [7:0] ST_ADDR = 8'h02;
  localparam [7:0] ST_CMD = 8'h04;
  localparam [7:0] ST_WDATA = 8'h08;
  localparam [7:0] ST_ACK = 8'h10;
  localparam [7:0] ST_RDATA = 8'h20;
  localparam [7:0] ST_MACK = 8'h40;
  localparam [7:0] ST_IGNORE = 8'h80;

  reg [7:0] state; // protocol state
  reg [7:0] ack_to; // state taken when our ack bit ends
  reg [3:0] bitcnt; // bits seen in the current byte
  reg [7:0] shreg; // receive shift register
  reg [7:0] txsh; // transmit shift register
  reg [3:0] ptr; // register pointer
  reg first; // next write byte is the first after the command
  reg more; // master acknowledged the byte just sent
  reg rd_busy; // a read transaction is open
  reg [7:0] ctrl; // control register
  reg dv_clr; // one-cycle request to clear a ready flag
  reg [3:0] dv_idx; // register whose flag is cleared
  reg [7:0] rd_byte; // byte the pointer selects for reading

  wire [3:0] mid; // synchroniser second stage
  wire [3:0] old; // synchroniser third stage
  wire [127:0] res_flat; // all sixteen bytes, result area filled
  wire [7:0] status; // composed status byte
  wire [6:0] own_addr; // our seven-bit address

  // pins cross into mclk through three stages
  msp_sync #(
    .WIDTH(4)
  ) u_sync (
    .mclk(mclk),
    .rst_b(rst_b),
    .din({addr_select_pin_1, addr_select_pin_0, sda_in, scl_in}),
    .mid(mid),
    .old(old)
  );

  reg scl_lvl; // accepted level of the clock wire
  reg sda_lvl; // accepted level of the data wire
  wire scl_ok = (mid[0] == old[0]); // clock stages two and three agree
  wire sda_ok = (mid[1] == old[1]); // data stages two and three agree

  // a new pin level counts only once stages two and three agree on it
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      scl_lvl <= 1'b1;
      sda_lvl <= 1'b1;
    end else begin
      scl_lvl <= scl_ok ? old[0] : scl_lvl;
      sda_lvl <= sda_ok ? old[1] : sda_lvl;
    end
  end

  // edges: the agreed level differs from the accepted one
  wire scl_rise = scl_ok & old[0] & ~scl_lvl;
  wire scl_fall = scl_ok & ~old[0] & scl_lvl;
  wire scl_high = scl_ok & old[0] & scl_lvl;
  wire sda_now = old[1];
  wire start_det = scl_high & sda_ok & ~old[1] & sda_lvl;
  wire stop_det = scl_high & sda_ok & old[1] & ~sda_lvl;
  wire rx_done = scl_fall & (bitcnt == `MSP_BYTE_BITS);

  // address from the select pins; one of four
  assign own_addr = {`MSP_BASE_ADDR} | {5'h00, old[3], old[2]};

  // own address in both directions, sync address for writes only
  wire addr_hit = (shreg[7:1] == own_addr) ||
                  ((shreg[7:1] == `MSP_SYNC_ADDR) && !shreg[0]);

  // only control and trigger take writes
  wire wr_ok = (ptr == `MSP_REG_CONTROL) || (ptr == `MSP_REG_TRIGGER);

  // data wire is only ever pulled low
  assign sda_out = 1'b0;

  // results are refused while a read is open
  assign res_ready = ~rd_busy;

  // control fields steer the measurement side
  assign ctrl_kelvin = ctrl[7];
  assign ctrl_single = ctrl[6];
  assign ctrl_mode = ctrl[4:0];
  // diode currents only once a remote channel is selected
  assign diode_drive_en = (ctrl[4:3] != 2'b00);

  // result byte store, one entry per register from 04 to 0F
  assign res_flat[31:0] = 32'h0000_0000;
  genvar gi;
  generate
    for (gi = 4; gi < 16; gi = gi + 1) begin : g_res
      localparam [3:0] IDX = gi;
      reg [7:0] val;
      reg fresh; // a result landed here last cycle
      // a new result wins over a registered flag clear asked for in its cycle
      always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
          val <= `MSP_REG_RESET;
          fresh <= 1'b0;
        end else begin
          fresh <= 1'b0;
          if (res_wr && !rd_busy && (res_idx == IDX)) begin
            val <= res_data;
            fresh <= 1'b1;
          end else if (dv_clr && (dv_idx == IDX) && !IDX[0] && !fresh) begin
            val[`MSP_DV_BIT] <= 1'b0;
          end
        end
      end
      assign res_flat[gi*8 +: 8] = val;
    end
  endgenerate

  // ready bits mirror the high-byte valid flags
  assign status = {1'b0, res_flat[119], res_flat[103], res_flat[87],
                   res_flat[71], res_flat[55], res_flat[39], conv_busy};

  // read mux; trigger address reads back status
  always @* begin
    if ((ptr == `MSP_REG_STATUS) || (ptr == `MSP_REG_TRIGGER)) begin
      rd_byte = status;
    end else if (ptr == `MSP_REG_CONTROL) begin
      rd_byte = ctrl;
    end else begin
      rd_byte = res_flat[ptr*8 +: 8];
    end
  end

  // protocol engine; all timing derives from the sampled clock and data edges
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state <= ST_IDLE;
      ack_to <= ST_IDLE;
      bitcnt <= 4'h0;
      shreg <= 8'h00;
      txsh <= 8'h00;
      ptr <= 4'h0;
      first <= 1'b0;
      more <= 1'b0;
      sda_oe <= 1'b0;
      rd_busy <= 1'b0;
      ctrl <= `MSP_REG_RESET;
      conv_trigger <= 1'b0;
      dv_clr <= 1'b0;
      dv_idx <= 4'h0;
    end else begin
      conv_trigger <= 1'b0;
      dv_clr <= 1'b0;
      if (start_det) begin
        // start or repeated start: fresh address phase
        state <= ST_ADDR;
        bitcnt <= 4'h0;
        sda_oe <= 1'b0;
        rd_busy <= 1'b0;
      end else if (stop_det) begin
        // stop frees the bus and ends any read
        state <= ST_IDLE;
        sda_oe <= 1'b0;
        rd_busy <= 1'b0;
      end else begin
        case (state)
          ST_ADDR: begin
            if (scl_rise) begin
              shreg <= {shreg[6:0], sda_now};
              bitcnt <= bitcnt + 4'h1;
            end else if (rx_done) begin
              bitcnt <= 4'h0;
              if (addr_hit) begin
                // hold data low over the ack clock
                sda_oe <= 1'b1;
                ack_to <= shreg[0] ? ST_RDATA : ST_CMD;
                state <= ST_ACK;
              end else begin
                state <= ST_IGNORE;
              end
            end
          end
          ST_CMD: begin
            if (scl_rise) begin
              shreg <= {shreg[6:0], sda_now};
              bitcnt <= bitcnt + 4'h1;
            end else if (rx_done) begin
              bitcnt <= 4'h0;
              ptr <= shreg[3:0];
              dv_clr <= 1'b1;
              dv_idx <= shreg[3:0];
              first <= 1'b1;
              sda_oe <= 1'b1;
              ack_to <= ST_WDATA;
              state <= ST_ACK;
            end
          end
          ST_WDATA: begin
            if (scl_rise) begin
              shreg <= {shreg[6:0], sda_now};
              bitcnt <= bitcnt + 4'h1;
            end else if (rx_done) begin
              bitcnt <= 4'h0;
              if (first || wr_ok) begin
                // first byte always taken; later ones only if writable
                if (ptr == `MSP_REG_CONTROL) begin
                  ctrl <= shreg;
                end else if (ptr == `MSP_REG_TRIGGER) begin
                  conv_trigger <= 1'b1;
                end
                ptr <= ptr + 4'h1;
                first <= 1'b0;
                sda_oe <= 1'b1;
                ack_to <= ST_WDATA;
                state <= ST_ACK;
              end else begin
                state <= ST_IGNORE;
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              // ack clock over: release, or start sending
              state <= ack_to;
              bitcnt <= 4'h0;
              if (ack_to == ST_RDATA) begin
                txsh <= rd_byte;
                sda_oe <= ~rd_byte[7];
                ptr <= ptr + 4'h1;
                dv_clr <= 1'b1;
                dv_idx <= ptr;
                rd_busy <= 1'b1;
              end else begin
                sda_oe <= 1'b0;
              end
            end
          end
          ST_RDATA: begin
            if (scl_fall) begin
              if (bitcnt == `MSP_LAST_TX_BIT) begin
                // let the master drive its ack bit
                sda_oe <= 1'b0;
                state <= ST_MACK;
              end else begin
                txsh <= {txsh[6:0], 1'b0};
                sda_oe <= ~txsh[6];
                bitcnt <= bitcnt + 4'h1;
              end
            end
          end
          ST_MACK: begin
            if (scl_rise) begin
              more <= ~sda_now;
            end else if (scl_fall) begin
              bitcnt <= 4'h0;
              if (more) begin
                // acked: next sequential register follows
                txsh <= rd_byte;
                sda_oe <= ~rd_byte[7];
                ptr <= ptr + 4'h1;
                dv_clr <= 1'b1;
                dv_idx <= ptr;
                state <= ST_RDATA;
              end else begin
                // nack: wait for stop, read stays open
                state <= ST_IGNORE;
              end
            end
          end
          default: begin
            // idle or not addressed: keep off the wire
            sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule

`default_nettype wire

// ### dv/msp_mst.sv
// two-wire bus master model pulling both wires low only
// assumes the bench resolves the wires with pull-ups and feeds sda back
`default_nettype none
module msp_mst (
  input wire logic mclk,
  input wire logic sda,
  output var logic scl_lo,
  output var logic sda_lo
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle: both wires released
  initial begin
    scl_lo = 1'h0;
    sda_lo = 1'h0;
  end
  // wait n falling mclk edges
  task hw(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // start or repeated start: data falls while clock high
  task start();
    sda_lo = 1'h0;
    hw(6);
    scl_lo = 1'h0;
    hw(8);
    sda_lo = 1'h1;
    hw(8);
    scl_lo = 1'h1;
  endtask
  // stop right after the last byte, data rises while clock high
  task stop();
    hw(4);
    sda_lo = 1'h1;
    hw(4);
    scl_lo = 1'h0;
    hw(8);
    sda_lo = 1'h0;
    hw(8);
  endtask
  // one bit: data set mid low phase, sampled before the clock falls
  task bit1(input logic b, output logic s);
    hw(4);
    sda_lo = !b;
    hw(4);
    scl_lo = 1'h0;
    hw(8);
    s = sda;
    scl_lo = 1'h1;
  endtask
  // msb first, then ninth bit; a high releases data
  task txb(input logic [7:0] d, input logic a, output logic [7:0] q, output logic s);
    for (int i = 7; i >= 0; i--)
      bit1(d[i], q[i]);
    bit1(a, s);
  endtask
endmodule
`default_nettype wire

// ### dv/msp_assertions.sv
// checker on the slave port outputs
// assumes a bind onto msp_slave_port
`default_nettype none
module msp_chk (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic res_ready,
  input wire logic conv_trigger,
  input wire logic ctrl_kelvin,
  input wire logic ctrl_single,
  input wire logic [4:0] ctrl_mode,
  input wire logic diode_drive_en
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);
  // cycles since the clock pin went low
  logic [3:0] lo_cnt;
  always_ff @(posedge mclk or negedge rst_b)
    if (!rst_b)
      lo_cnt <= 4'hF;
    else if (scl_in)
      lo_cnt <= 4'h0;
    else if (lo_cnt != 4'hF)
      lo_cnt <= lo_cnt + 4'h1;
  // a few cycles into a clock low phase
  sequence s_lo;
    !scl_in && lo_cnt inside {[2:7]};
  endsequence
  // pulse in clock low, gone next cycle
  sequence s_end;
    !scl_in ##1 !conv_trigger;
  endsequence
  property p_out;
    sda_out == 1'h0;
  endproperty
  property p_oe;
    $changed(sda_oe) |-> s_lo;
  endproperty
  property p_rdyf;
    $fell(res_ready) |-> s_lo;
  endproperty
  property p_rdyr;
    $rose(res_ready) |-> scl_in;
  endproperty
  property p_ctl;
    $changed({ctrl_kelvin, ctrl_single, ctrl_mode}) |-> !scl_in;
  endproperty
  property p_trg;
    conv_trigger |-> s_end;
  endproperty
  property p_dio;
    diode_drive_en == (ctrl_mode[4:3] != 2'h0);
  endproperty
  property p_rst;
    $rose(rst_b) |-> ctrl_mode == 5'h00 && res_ready && !sda_oe;
  endproperty
  a_out: assert property (p_out)
    else $error("data driven high");
  a_oe: assert property (p_oe)
    else $error("data drive moved off clock low");
  a_rdyf: assert property (p_rdyf)
    else $error("results paused off a load");
  a_rdyr: assert property (p_rdyr)
    else $error("results resumed off a stop");
  a_ctl: assert property (p_ctl)
    else $error("control moved off clock low");
  a_trg: assert property (p_trg)
    else $error("trigger not a clean pulse");
  a_dio: assert property (p_dio)
    else $error("diode drive wrong");
  a_rst: assert property (p_rst)
    else $error("reset values wrong");
endmodule
`default_nettype wire

// ### dv/testbench.sv
// bench for the monitor two-wire slave port
// assumes the master model and checker are compiled first
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'h0;
  logic rst_b = 1'h0;
  logic [1:0] pins = 2'h0;
  logic res_wr = 1'h0;
  logic [3:0] res_idx = 4'h0;
  logic [7:0] res_data = 8'h00;
  logic conv_busy = 1'h0;
  logic [6:0] adr = 7'h4C;
  logic [7:0] q;
  logic r;
  wire scl_lo, sda_lo, sda_out, sda_oe, res_ready, conv_trigger;
  wire ctrl_kelvin, ctrl_single, diode_drive_en;
  wire [4:0] ctrl_mode;
  // pulled-up wires, low if any party pulls
  wire scl = !scl_lo;
  wire sda = !(sda_lo || (sda_oe && !sda_out));
  int mismatches = 0;
  int n_tests = 0;
  int cyc = 0;
  int trigs = 0;
  always #5 mclk = ~mclk;
  msp_slave_port u_dut (.mclk(mclk), .rst_b(rst_b), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .addr_select_pin_0(pins[0]),
    .addr_select_pin_1(pins[1]), .res_wr(res_wr), .res_idx(res_idx),
    .res_data(res_data), .res_ready(res_ready), .conv_busy(conv_busy),
    .conv_trigger(conv_trigger), .ctrl_kelvin(ctrl_kelvin), .ctrl_single(ctrl_single),
    .ctrl_mode(ctrl_mode), .diode_drive_en(diode_drive_en));
  msp_mst u_m (.mclk(mclk), .sda(sda), .scl_lo(scl_lo), .sda_lo(sda_lo));
  // count trigger pulses; cut a hang short
  always @(posedge mclk) begin
    cyc++;
    if (conv_trigger === 1'h1)
      trigs++;
    if (cyc == 40000) begin
      mismatches++;
      print_verdict();
    end
  end
  task print_verdict();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task byt(input logic [7:0] d, input logic nak);
    u_m.txb(d, 1'h1, q, r);
    chk({7'h00, r}, {7'h00, nak});
  endtask
  task rdb(input logic more, input logic [7:0] exp);
    u_m.txb(8'hFF, !more, q, r);
    chk(q, exp);
  endtask
  task wsel(input logic [6:0] a, input logic [7:0] c);
    u_m.start();
    byt({a, 1'h0}, 1'h0);
    byt(c, 1'h0);
  endtask
  task rsel(input logic [7:0] c);
    wsel(adr, c);
    u_m.start();
    byt({adr, 1'h1}, 1'h0);
  endtask
  task post(input logic [3:0] i, input logic [7:0] d);
    res_idx = i;
    res_data = d;
    res_wr = 1'h1;
    @(negedge mclk);
    res_wr = 1'h0;
    @(negedge mclk);
  endtask
  task t_reset();
    rsel(8'h01);
    rdb(1'h1, 8'h00);
    rdb(1'h0, 8'h00);
    u_m.stop();
  endtask
  // word write: control then trigger, command upper nibble ignored
  task t_write();
    wsel(adr, 8'hF1);
    byt(8'hC9, 1'h0);
    byt(8'h5A, 1'h0);
    u_m.stop();
    chk({ctrl_kelvin, ctrl_single, 1'h0, ctrl_mode}, 8'hC9);
    chk(trigs[7:0], 8'h01);
  endtask
  // each strap value, and its neighbour refused
  task t_addr();
    for (int k = 0; k < 4; k++) begin
      pins = k[1:0];
      adr = 7'h4C | {5'h00, k[1:0]};
      u_m.hw(8);
      u_m.start();
      byt({adr ^ 7'h01, 1'h0}, 1'h1);
      u_m.stop();
      wsel(adr, 8'h01);
      byt({3'h0, k[1:0], 3'h0}, 1'h0);
      u_m.stop();
      chk({6'h00, ctrl_mode[4:3]}, {6'h00, k[1:0]});
    end
  endtask
  task t_sync();
    wsel(7'h77, 8'h02);
    byt(8'h00, 1'h0);
    u_m.stop();
    chk(trigs[7:0], 8'h02);
    u_m.start();
    byt({7'h77, 1'h1}, 1'h1);
    u_m.stop();
    wsel(adr, 8'h03);
    byt(8'h55, 1'h0);
    byt(8'h55, 1'h1);
    u_m.stop();
  endtask
  // wrap to status, pause during reads, flag clear on addressing
  task t_read();
    conv_busy = 1'h1;
    post(4'h4, 8'h85);
    post(4'hF, 8'h3C);
    rsel(8'h0F);
    rdb(1'h1, 8'h3C);
    chk({7'h00, res_ready}, 8'h00);
    post(4'hF, 8'h11);
    rdb(1'h0, 8'h03);
    u_m.stop();
    chk({7'h00, res_ready}, 8'h01);
    rsel(8'h04);
    rdb(1'h1, 8'h05);
    rdb(1'h0, 8'h00);
    u_m.stop();
    rsel(8'h0F);
    rdb(1'h1, 8'h3C);
    rdb(1'h0, 8'h01);
    u_m.stop();
  endtask
  // reset in mid-run: control, diode drive and results back to zero
  task t_rst();
    rst_b = 1'h0;
    u_m.hw(3);
    chk({ctrl_kelvin, ctrl_single, 1'h0, ctrl_mode}, 8'h00);
    chk({7'h00, diode_drive_en}, 8'h00);
    rst_b = 1'h1;
    u_m.hw(8);
    rsel(8'h0F);
    rdb(1'h1, 8'h00);
    rdb(1'h0, 8'h01);
    u_m.stop();
  endtask
  initial begin
    repeat (3) @(negedge mclk);
    rst_b = 1'h1;
    u_m.hw(8);
    t_reset();
    t_write();
    t_addr();
    t_sync();
    t_read();
    t_rst();
    print_verdict();
  end
endmodule
bind msp_slave_port msp_chk u_chk (.mclk, .rst_b, .scl_in, .sda_out, .sda_oe, .res_ready,
  .conv_trigger, .ctrl_kelvin, .ctrl_single, .ctrl_mode, .diode_drive_en);
`default_nettype wire
